/* include/wdp_regs.svh */
// register map, field positions, reset values and counts of the watchdog
// assumes a 32-bit classic wishbone slave with byte addresses on adr_i
`ifndef WDP_REGS_SVH
`define WDP_REGS_SVH

// ----------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------
`define WDP_ADR_W 18
`define WDP_OFF_REFRESH 18'h00000
`define WDP_OFF_START 18'h00004
`define WDP_OFF_CTRL 18'h00008
`define WDP_OFF_PWR1 18'h0000c
`define WDP_OFF_PROTECT 18'h00010
`define WDP_OFF_STATUS 18'h00014
`define WDP_OFF_MASK 18'h00018
`define WDP_OFF_COUNT 18'h0001c
`define WDP_IDX_OPTION 16'hffff
`define WDP_OFF_OPTION {`WDP_IDX_OPTION, 2'b00}

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WDP_BIT_RATIO 7
`define WDP_BIT_ACTION 2
`define WDP_BIT_PROTECT 7
`define WDP_BIT_AUTO 0
`define WDP_BIT_UFLOW 0

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define WDP_RELOAD_NORM 15'h7fff
`define WDP_RELOAD_PROT 15'h0fff
`define WDP_PRE_FILL16 7'h70
`define WDP_PRE_TERM 7'h7f
`define WDP_SEQ_FIRST 8'h00
`define WDP_SEQ_SECOND 8'hff
`define WDP_RST_CTRL 1'b0
`define WDP_RST_ACTION 1'b0
`define WDP_RST_MASK 1'b0

`endif

/* include/wdp_pkg.sv */
// types shared by the watchdog design and its bench
// assumes wdp_regs.svh holds all numbers
package wdp_pkg;

    // observable state of the watchdog, all bits from flip-flops
    typedef struct packed {
        logic running;
        logic protect;
        logic action_reset;
    } wdp_state_t;

endpackage

/* hdl/wdp_top.sv */
// watchdog with prescaler, 15-bit down counter and protected count source
// assumes a wishbone master on clk_i, cpu clock given as enable pulses,
// low-speed oscillator as an asynchronous pin, option byte static at reset
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "wdp_regs.svh"

module wdp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [`WDP_ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] option_byte_i,
    input wire logic cpu_clk_en_i,
    input wire logic stop_mode_i,
    input wire logic wait_mode_i,
    input wire logic loco_clk_i,
    output logic irq_o,
    output logic irq_pulse_o,
    output logic wdt_reset_o,
    output logic loco_on_o,
    output wdp_pkg::wdp_state_t state_o
);
    import wdp_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [14:0] cnt_q;
    logic [6:0] pre_q;
    logic [7:0] opt_q;
    logic run_q, prot_q, act_q, ratio_q, saw00_q, ack_q;
    logic stat_q, mask_q, irq_q, pulse_q, wreset_q;
    logic [2:0] sync_q;
    logic lvl_q;
    logic [31:0] dat_q;

    function automatic logic hit(input logic [`WDP_ADR_W-1:0] a, input logic [`WDP_ADR_W-1:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------------
    logic wb_req, wr, rd, refresh_fire, prot_set, start_wr;
    logic loco_rise, cpu_adv, cpu_tick, prot_tick, tick, uf;
    logic [14:0] reload_val;
    logic stat_d;

    assign wb_req = ce_i & cyc_i & stb_i & ~ack_q;
    assign wr = wb_req & we_i & sel_i[0];
    assign rd = wb_req & ~we_i;
    assign refresh_fire = wr & hit(adr_i, `WDP_OFF_REFRESH) & saw00_q & (dat_i[7:0] == `WDP_SEQ_SECOND);
    assign prot_set = wr & hit(adr_i, `WDP_OFF_PROTECT) & dat_i[`WDP_BIT_PROTECT] & ~prot_q;
    assign start_wr = wr & hit(adr_i, `WDP_OFF_START);

    // classic single-cycle answer: ack one cycle after the strobe, then low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else if (ce_i)
            ack_q <= cyc_i & stb_i & ~ack_q;
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_q <= 32'h0000_0000;
        else if (rd)
        begin
            dat_q <= 32'h0000_0000;
            if (hit(adr_i, `WDP_OFF_CTRL))
                dat_q[`WDP_BIT_RATIO] <= ratio_q;
            if (hit(adr_i, `WDP_OFF_PWR1))
                dat_q[`WDP_BIT_ACTION] <= act_q;
            if (hit(adr_i, `WDP_OFF_PROTECT))
                dat_q[`WDP_BIT_PROTECT] <= prot_q;
            if (hit(adr_i, `WDP_OFF_STATUS))
                dat_q[`WDP_BIT_UFLOW] <= stat_q;
            if (hit(adr_i, `WDP_OFF_MASK))
                dat_q[`WDP_BIT_UFLOW] <= mask_q;
            if (hit(adr_i, `WDP_OFF_COUNT))
                dat_q[14:0] <= cnt_q;
            if (hit(adr_i, `WDP_OFF_OPTION))
                dat_q[7:0] <= opt_q;
        end
    end

    // ------------------------------------------------------------------
    // option byte and start control
    // ------------------------------------------------------------------
    // captured while the synchronous reset is held; no bus path writes it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            opt_q <= option_byte_i;
    end

    // auto start one cycle after release, or on any start write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            run_q <= 1'b0;
        else if (ce_i && (!opt_q[`WDP_BIT_AUTO] || start_wr))
            run_q <= 1'b1;
    end

    // refresh sequence: 00h arms, ffh fires, anything else disarms
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            saw00_q <= 1'b0;
        else if (wr && hit(adr_i, `WDP_OFF_REFRESH))
            saw00_q <= (dat_i[7:0] == `WDP_SEQ_FIRST);
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ratio_q <= `WDP_RST_CTRL;
        else if (wr && hit(adr_i, `WDP_OFF_CTRL))
            ratio_q <= dat_i[`WDP_BIT_RATIO];
    end

    // protection is set-only; it forces reset action and holds it there
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prot_q <= 1'b0;
        else if (prot_set)
            prot_q <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            act_q <= `WDP_RST_ACTION;
        else if (prot_set || prot_q)
            act_q <= 1'b1;
        else if (wr && hit(adr_i, `WDP_OFF_PWR1))
            act_q <= dat_i[`WDP_BIT_ACTION];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask_q <= `WDP_RST_MASK;
        else if (wr && hit(adr_i, `WDP_OFF_MASK))
            mask_q <= dat_i[`WDP_BIT_UFLOW];
    end

    // ------------------------------------------------------------------
    // low-speed oscillator sampling
    // ------------------------------------------------------------------
    // three stages; the level moves only when stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_q <= 3'b000;
            lvl_q <= 1'b0;
        end
        else if (ce_i)
        begin
            sync_q <= {sync_q[1:0], loco_clk_i};
            if (sync_q[1] == sync_q[2])
                lvl_q <= sync_q[2];
        end
    end

    assign loco_rise = ~lvl_q & sync_q[1] & sync_q[2];

    // ------------------------------------------------------------------
    // prescaler and count ticks
    // ------------------------------------------------------------------
    // halted in stop or wait, nothing reloads the phase: resume is exact
    assign cpu_adv = ce_i & run_q & ~prot_q & cpu_clk_en_i & ~stop_mode_i & ~wait_mode_i;
    // free-running 7-bit phase; low nibble alone decides at ratio 16
    assign cpu_tick = cpu_adv & ((pre_q | (ratio_q ? 7'h00 : `WDP_PRE_FILL16)) == `WDP_PRE_TERM);
    // oscillator ticks ignore cpu clock, stop and wait entirely
    assign prot_tick = ce_i & run_q & prot_q & loco_rise;
    assign tick = cpu_tick | prot_tick;
    assign uf = tick & (cnt_q == 15'h0000);
    assign reload_val = prot_q ? `WDP_RELOAD_PROT : `WDP_RELOAD_NORM;

    // refresh leaves the phase alone, so a period may come out short
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pre_q <= 7'h00;
        else if (cpu_adv)
            pre_q <= pre_q + 7'h01;
    end

    // ------------------------------------------------------------------
    // 15-bit down counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_q <= `WDP_RELOAD_NORM;
        else if (prot_set)
            cnt_q <= `WDP_RELOAD_PROT;
        else if (refresh_fire || uf)
            cnt_q <= reload_val;
        else if (tick)
            cnt_q <= cnt_q - 15'h0001;
    end

    // ------------------------------------------------------------------
    // underflow action and interrupt
    // ------------------------------------------------------------------
    // read of status clears it, a new underflow in that cycle wins
    always_comb
    begin
        stat_d = stat_q;
        if (rd && hit(adr_i, `WDP_OFF_STATUS))
            stat_d = 1'b0;
        if (uf && !act_q)
            stat_d = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (ce_i)
        begin
            stat_q <= stat_d;
            irq_q <= stat_d & mask_q;
        end
    end

    // one-cycle pulses; the reset request is for the chip reset controller
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pulse_q <= 1'b0;
            wreset_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pulse_q <= uf & ~act_q;
            wreset_q <= uf & act_q;
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign irq_o = irq_q;
    assign irq_pulse_o = pulse_q;
    assign wdt_reset_o = wreset_q;
    assign loco_on_o = prot_q;
    assign state_o = '{running: run_q, protect: prot_q, action_reset: act_q};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_refresh_reload: assert property (refresh_fire && !prot_set |=> cnt_q == reload_val)
        else $error("refresh did not reload counter");
    a_underflow_reload: assert property (uf && !prot_set |=> cnt_q == reload_val)
        else $error("underflow did not reload counter");
    a_stop_holds: assert property (!prot_q && (stop_mode_i || wait_mode_i) && !prot_set && !refresh_fire
        |=> $stable(cnt_q) && $stable(pre_q))
        else $error("counter moved in stop or wait mode");
    a_idle_holds: assert property (!run_q && !prot_set && !refresh_fire |=> $stable(cnt_q))
        else $error("counter moved before start");
    a_prescale_keep: assert property (refresh_fire |=> pre_q == $past(pre_q) + {6'h00, $past(cpu_adv)})
        else $error("refresh disturbed prescaler");
    a_irq_path: assert property (uf && !act_q |=> stat_q && irq_pulse_o && !wdt_reset_o)
        else $error("underflow did not raise interrupt");
    a_reset_path: assert property (uf && act_q |=> wdt_reset_o && !irq_pulse_o)
        else $error("underflow did not request reset");
    a_protect_force: assert property (prot_set |=> prot_q && loco_on_o && act_q && cnt_q == `WDP_RELOAD_PROT)
        else $error("protect enable not applied");
    a_protect_count: assert property (prot_tick && cnt_q != 15'h0000 && !refresh_fire
        |=> cnt_q == $past(cnt_q) - 15'h0001)
        else $error("protected count did not decrement");
    a_option_fixed: assert property (!$past(rst_i) |-> $stable(opt_q))
        else $error("option byte changed");

    c_irq: cover property (uf && !act_q);
    c_reset: cover property (uf && act_q);
    c_refresh: cover property (refresh_fire);
    c_protect: cover property (prot_set ##[1:50] prot_tick);

endmodule

/* sim/tb_wdp_top.sv */
// self-checking bench for the watchdog: bus access, counting, halting, protection
// assumes wdp_top, wdp_pkg and wdp_regs.svh; ce_i is high throughout except for one 300-cycle window
`timescale 1ns/1ps
`include "wdp_regs.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_wdp_top;
    import wdp_pkg::*;
    logic clk_i, rst_i, ce_i, we_i, cyc_i, stb_i, cpu_clk_en_i, stop_mode_i, wait_mode_i, loco_clk_i;
    logic [`WDP_ADR_W-1:0] adr_i;
    logic [31:0] dat_i, dat_o, rd, held;
    logic [3:0] sel_i;
    logic [7:0] option_byte_i;
    logic ack_o, irq_o, irq_pulse_o, wdt_reset_o, loco_on_o, irq_seen;
    wdp_state_t state_o;
    int error_cnt, total_checks, found;

    wdp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .option_byte_i(option_byte_i), .cpu_clk_en_i(cpu_clk_en_i), .stop_mode_i(stop_mode_i),
        .wait_mode_i(wait_mode_i), .loco_clk_i(loco_clk_i), .irq_o(irq_o), .irq_pulse_o(irq_pulse_o),
        .wdt_reset_o(wdt_reset_o), .loco_on_o(loco_on_o), .state_o(state_o));

    // 40 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------
    // classic cycle: hold everything until ack is sampled, then drop for a cycle
    task automatic wb(input logic w, input logic [`WDP_ADR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        `CHK(ack_o, 1'b1)
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [`WDP_ADR_W-1:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // counter lies in a window; the prescaler phase blurs each figure by one tick
    task automatic cnt_in(input logic [31:0] lo, input logic [31:0] hi);
        wb(1'b0, `WDP_OFF_COUNT, 32'h0);
        `CHK((rd >= lo) && (rd <= hi), 1'b1)
    endtask

    // called just after an edge, or at time zero: six edges see reset high
    task automatic do_reset(input logic [7:0] opt);
        option_byte_i <= opt;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: tests need roughly 43k cycles
    initial
    begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {we_i, cyc_i, stb_i, stop_mode_i, wait_mode_i, loco_clk_i} = '0;
        rst_i = 1'b1;
        {ce_i, cpu_clk_en_i} = 2'b11;
        adr_i = '0;
        dat_i = '0;
        sel_i = 4'hf;
        option_byte_i = 8'ha5;
        irq_seen = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        do_reset(8'ha5);
        repeat (200) @(posedge clk_i);
        rd_chk(`WDP_OFF_COUNT, 32'h7fff);
        `CHK(state_o.running, 1'b0)
        rd_chk(`WDP_OFF_OPTION, 32'ha5);
        wb(1'b1, `WDP_OFF_OPTION, 32'h0);
        rd_chk(`WDP_OFF_OPTION, 32'ha5);
        rd_chk(`WDP_OFF_CTRL, 32'h0);
        rd_chk(18'h00100, 32'h0);
        wb(1'b1, `WDP_OFF_MASK, 32'h1);
        rd_chk(`WDP_OFF_MASK, 32'h1);
        rd_chk(`WDP_OFF_STATUS, 32'h0);
        `CHK(irq_o, 1'b0)
        $display("test reset and registers done");
        // start write, then ten /16 ticks of cpu clock
        wb(1'b1, `WDP_OFF_START, 32'h1);
        repeat (160) @(posedge clk_i);
        cnt_in(32'h7ff4, 32'h7ff6);
        // a lone ffh must not reload, a full 00h then ffh pair must
        wb(1'b1, `WDP_OFF_REFRESH, 32'hff);
        cnt_in(32'h7ff0, 32'h7ff6);
        wb(1'b1, `WDP_OFF_REFRESH, 32'h0);
        wb(1'b1, `WDP_OFF_REFRESH, 32'hff);
        cnt_in(32'h7ffe, 32'h7fff);
        $display("test start and refresh done");
        // stop then wait: counter freezes and resumes from the held value
        for (int m = 0; m < 2; m++)
        begin
            stop_mode_i <= (m == 0);
            wait_mode_i <= (m == 1);
            wb(1'b0, `WDP_OFF_COUNT, 32'h0);
            held = rd;
            repeat (300) @(posedge clk_i);
            rd_chk(`WDP_OFF_COUNT, held);
            stop_mode_i <= 1'b0;
            wait_mode_i <= 1'b0;
            repeat (64) @(posedge clk_i);
            cnt_in(held - 32'h6, held - 32'h3);
        end
        // /128: four ticks in 512 cycles, where /16 would give thirty-two
        wb(1'b1, `WDP_OFF_CTRL, 32'h80);
        rd_chk(`WDP_OFF_CTRL, 32'h80);
        wb(1'b1, `WDP_OFF_REFRESH, 32'h0);
        wb(1'b1, `WDP_OFF_REFRESH, 32'hff);
        repeat (512) @(posedge clk_i);
        cnt_in(32'h7ffa, 32'h7ffc);
        $display("test halting and ratio done");
        // auto start after a second reset, no software action
        do_reset(8'ha4);
        repeat (200) @(posedge clk_i);
        cnt_in(32'h7ff1, 32'h7ff4);
        // clock enable low freezes counting; edges either side allow one tick at most
        wb(1'b0, `WDP_OFF_COUNT, 32'h0);
        held = rd;
        ce_i <= 1'b0;
        repeat (300) @(posedge clk_i);
        ce_i <= 1'b1;
        cnt_in(held - 32'h1, held);
        // protection: 0fffh, oscillator on, action forced to reset
        wb(1'b1, `WDP_OFF_PROTECT, 32'h80);
        rd_chk(`WDP_OFF_COUNT, 32'h0fff);
        wb(1'b1, `WDP_OFF_PWR1, 32'h0);
        rd_chk(`WDP_OFF_PWR1, 32'h4);
        `CHK(loco_on_o, 1'b1)
        `CHK(state_o.action_reset, 1'b1)
        // cpu clock gone and wait mode on: oscillator edges alone must count
        cpu_clk_en_i <= 1'b0;
        wait_mode_i <= 1'b1;
        found = 0;
        for (int e = 1; e <= 4200 && found == 0; e++)
        begin
            for (int k = 0; k < 10; k++)
            begin
                @(posedge clk_i);
                loco_clk_i <= (k < 5);
                if (wdt_reset_o === 1'b1)
                    found = e;
                if (irq_pulse_o === 1'b1)
                    irq_seen = 1'b1;
            end
        end
        `CHK(found, 4096)
        `CHK(irq_seen, 1'b0)
        rd_chk(`WDP_OFF_COUNT, 32'h0fff);
        $display("test protection done");
        end_sim();
    end
endmodule
